// ### include/bic_pkg.sv
// Constants and types for the bit-level two-wire bus control and status block
package bic_pkg;
   // Register addresses on the special function register port
   localparam logic [7:0] ADDR_CTL   = 8'hd8;
   localparam logic [7:0] ADDR_BIT   = 8'hd9;
   localparam logic [7:0] ADDR_START = 8'hda;
   // Bit positions in bus_control_status
   localparam int B_DATA  = 7;
   localparam int B_CLK   = 6;
   localparam int B_RISE  = 5;
   localparam int B_BUSY  = 4;
   localparam int B_RDONE = 3;
   localparam int B_WDONE = 2;
   localparam int B_STR   = 1;
   localparam int B_EN    = 0;
   // Bit position of the start flag in start_interrupt_reg
   localparam int B_START = 7;
   // Reset values
   localparam logic      LINE_IDLE = 1'b1;
   localparam logic [7:0] RST_CTL  = 8'hc0;
   localparam logic [7:0] RD_ZERO  = 8'h00;
   // Timing, in picoseconds per period and in crystal periods
   localparam int CLK_PS          = 8000;
   localparam int CRYSTAL_CLOCK_PS         = 8000;
   localparam int AUTO_DELAY_CRYSTAL_CLOCK = 28;
   localparam int AUTO_HIGH_CRYSTAL_CLOCK  = 100;
   localparam int AUTO_PAUSE_CRYSTAL_CLOCK = 20;
   localparam int RISE_MIN_CRYSTAL_CLOCK   = 8;
   localparam int SYNC_STAGES     = 2;
   // Derived cycle counts; least times round up, none below one cycle
   localparam int AUTO_DELAY_CYC = (AUTO_DELAY_CRYSTAL_CLOCK * CRYSTAL_CLOCK_PS + CLK_PS - 1) / CLK_PS;
   localparam int AUTO_HIGH_CYC  = (AUTO_HIGH_CRYSTAL_CLOCK * CRYSTAL_CLOCK_PS + CLK_PS - 1) / CLK_PS;
   localparam int AUTO_PAUSE_CYC = (AUTO_PAUSE_CRYSTAL_CLOCK * CRYSTAL_CLOCK_PS + CLK_PS - 1) / CLK_PS;
   localparam int RISE_MIN_CYC   = (RISE_MIN_CRYSTAL_CLOCK * CRYSTAL_CLOCK_PS + CLK_PS - 1) / CLK_PS;
   localparam int FILT_LEN_DEF   = RISE_MIN_CYC - SYNC_STAGES;
   localparam int CNT_W          = 8;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
   // Auto-clock sequencer states
   typedef enum logic [1:0] {AC_IDLE, AC_DELAY, AC_HIGH} bic_auto_e;
endpackage

// ### rtl/bic_ctl.sv
// Bit-level two-wire bus control, status, auto-clock and clock stretching
`timescale 1ns/1ps
module bic_ctl
   import bic_pkg::*;
#(
   parameter int FILT_LEN = FILT_LEN_DEF
)(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_rd,
   input  wire logic       sfr_rmw,
   input  wire logic       sfr_wr,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata_r,
   input  wire logic       scl_in,
   output logic            scl_out_r,
   output logic            scl_oe_n_r,
   input  wire logic       sda_in,
   output logic            sda_out_r,
   output logic            sda_oe_n_r
);
   logic             scl_f;
   logic             sda_f;
   logic             scl_d_r;
   logic             sda_d_r;
   logic             data_out_bit_r;
   logic             clock_out_bit_r;
   logic             stretch_control_r;
   logic             serial_io_enable_r;
   logic             data_in_r;
   logic             clock_rise_flag_r;
   logic             bus_busy_flag_r;
   logic             start_int_r;
   logic             start_pend_r;
   logic             stretch_hold_flag_r;
   logic             arb_lost_r;
   bic_auto_e        auto_st_r;
   logic [CNT_W-1:0] auto_cnt_r;
   logic             scl_rise;
   logic             scl_fall;
   logic             start_ev;
   logic             stop_ev;
   logic             ctl_wr;
   logic             bit_acc;
   logic             rise_clr;
   logic             read_bit_done;
   logic             write_bit_done;
   logic             auto_high;
   logic             auto_launch;
   logic             scl_pull;

   // Line inputs pass synchroniser and filter before anything reads them
   bic_filter #(.FILT_LEN(FILT_LEN)) u_scl_filt (
      .ref_clk (ref_clk),
      .rst     (rst),
      .line_in (scl_in),
      .filt_r  (scl_f)
   );
   bic_filter #(.FILT_LEN(FILT_LEN)) u_sda_filt (
      .ref_clk (ref_clk),
      .rst     (rst),
      .line_in (sda_in),
      .filt_r  (sda_f)
   );
   // Delayed copies of the filtered lines for edge detection
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         scl_d_r <= LINE_IDLE;
         sda_d_r <= LINE_IDLE;
      end
      else
      begin
         scl_d_r <= scl_f;
         sda_d_r <= sda_f;
      end
   end
   // Bus events and register access decode
   assign scl_rise    = scl_f && !scl_d_r;
   assign scl_fall    = !scl_f && scl_d_r;
   assign start_ev    = serial_io_enable_r && scl_f && scl_d_r && !sda_f && sda_d_r;
   assign stop_ev     = scl_f && scl_d_r && sda_f && !sda_d_r;
   assign ctl_wr      = sfr_wr && (sfr_addr == ADDR_CTL);
   assign bit_acc     = (sfr_wr || sfr_rd) && (sfr_addr == ADDR_BIT);
   assign rise_clr    = bit_acc || (ctl_wr && !sfr_wdata[B_RISE]);
   assign auto_launch = bit_acc && !clock_out_bit_r && serial_io_enable_r;
   assign auto_high   = (auto_st_r == AC_HIGH);
   // Finished flags are derived, so clearing the rise flag clears them too
   assign read_bit_done  = clock_rise_flag_r && !scl_f && !start_int_r && bus_busy_flag_r;
   assign write_bit_done = read_bit_done && !arb_lost_r;
   // Control bits; the data bit is one store shared by both registers
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         data_out_bit_r     <= RST_CTL[B_DATA];
         clock_out_bit_r    <= RST_CTL[B_CLK];
         stretch_control_r  <= RST_CTL[B_STR];
         serial_io_enable_r <= RST_CTL[B_EN];
      end
      else if (ctl_wr)
      begin
         data_out_bit_r     <= sfr_wdata[B_DATA];
         clock_out_bit_r    <= sfr_wdata[B_CLK];
         stretch_control_r  <= sfr_wdata[B_STR];
         serial_io_enable_r <= sfr_wdata[B_EN];
      end
      else if (bit_acc && sfr_wr)
         data_out_bit_r <= sfr_wdata[B_DATA];
   end
   // Input data latch, rise flag and arbitration check; a new edge beats a clear
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         data_in_r         <= LINE_IDLE;
         clock_rise_flag_r <= 1'b0;
         arb_lost_r        <= 1'b0;
      end
      else if (scl_rise)
      begin
         data_in_r         <= sda_f;
         clock_rise_flag_r <= 1'b1;
         arb_lost_r        <= data_out_bit_r && !sda_f;
      end
      else if (rise_clr)
      begin
         clock_rise_flag_r <= 1'b0;
         arb_lost_r        <= 1'b0;
      end
   end
   // Bus busy between start and stop; cleared when the hardware is off
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         bus_busy_flag_r <= 1'b0;
      else if (!serial_io_enable_r)
         bus_busy_flag_r <= 1'b0;
      else if (start_ev)
         bus_busy_flag_r <= 1'b1;
      else if (stop_ev)
         bus_busy_flag_r <= 1'b0;
   end

   // Start flag waits for the clock fall after a start; set wins over clear
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         start_pend_r <= 1'b0;
         start_int_r  <= 1'b0;
      end
      else
      begin
         if (start_ev)
            start_pend_r <= 1'b1;
         else if (scl_fall || !serial_io_enable_r)
            start_pend_r <= 1'b0;
         if (start_pend_r && scl_fall)
            start_int_r <= 1'b1;
         else if (bit_acc || (sfr_wr && sfr_addr == ADDR_START && !sfr_wdata[B_START]))
            start_int_r <= 1'b0;
      end
   end

   // Hidden stretch flag; a set event in the access cycle still wins
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         stretch_hold_flag_r <= 1'b0;
      else if (!serial_io_enable_r)
         stretch_hold_flag_r <= 1'b0;
      else if (start_ev || (scl_fall && stretch_control_r))
         stretch_hold_flag_r <= 1'b1;
      else if (bit_acc)
         stretch_hold_flag_r <= 1'b0;
   end

   // Auto-clock: delay, then a high pulse that pauses while the line is held low, but not in its first 20 cycles
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         auto_st_r  <= AC_IDLE;
         auto_cnt_r <= CNT_ZERO;
      end
      else if (auto_launch)
      begin
         auto_st_r  <= AC_DELAY;
         auto_cnt_r <= CNT_ONE;
      end
      else
      begin
         case (auto_st_r)
            AC_DELAY:
               if (auto_cnt_r == CNT_W'(AUTO_DELAY_CYC - 1))
               begin
                  auto_st_r  <= AC_HIGH;
                  auto_cnt_r <= CNT_ZERO;
               end
               else
                  auto_cnt_r <= auto_cnt_r + CNT_ONE;
            AC_HIGH:
               if (auto_cnt_r == CNT_W'(AUTO_HIGH_CYC - 1))
               begin
                  auto_st_r  <= AC_IDLE;
                  auto_cnt_r <= CNT_ZERO;
               end
               else if (auto_cnt_r < CNT_W'(AUTO_PAUSE_CYC) || scl_f)
                  auto_cnt_r <= auto_cnt_r + CNT_ONE;
            default:
            begin
               auto_st_r  <= AC_IDLE;
               auto_cnt_r <= CNT_ZERO;
            end
         endcase
      end
   end

   // Lines are only ever pulled low or released; disabled hardware releases both
   assign scl_pull = serial_io_enable_r
                     && ((!clock_out_bit_r && !auto_high) || stretch_hold_flag_r);
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         scl_oe_n_r <= 1'b1;
         sda_oe_n_r <= 1'b1;
         scl_out_r  <= 1'b0;
         sda_out_r  <= 1'b0;
      end
      else
      begin
         scl_oe_n_r <= !scl_pull;
         sda_oe_n_r <= !(serial_io_enable_r && !data_out_bit_r);
         scl_out_r  <= 1'b0;
         sda_out_r  <= 1'b0;
      end
   end

   // Registered read data; read-modify-write sees the output bits
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         sfr_rdata_r <= RD_ZERO;
      else if (sfr_rd && sfr_addr == ADDR_CTL)
         sfr_rdata_r <= {sfr_rmw ? data_out_bit_r : data_in_r,
                         sfr_rmw ? clock_out_bit_r : scl_f,
                         clock_rise_flag_r, bus_busy_flag_r, read_bit_done,
                         write_bit_done, stretch_control_r, serial_io_enable_r};
      else if (sfr_rd && sfr_addr == ADDR_BIT)
         sfr_rdata_r <= {data_in_r, RD_ZERO[6:0]};
      else if (sfr_rd && sfr_addr == ADDR_START)
         sfr_rdata_r <= {start_int_r, RD_ZERO[6:0]};
      else if (sfr_rd)
         sfr_rdata_r <= RD_ZERO;
   end

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_capture;
      scl_rise |=> data_in_r == $past(sda_f);
   endproperty
   a_capture: assert property (p_capture) else $error("data bit not latched");
   property p_rise;
      scl_rise |=> clock_rise_flag_r;
   endproperty
   a_rise: assert property (p_rise) else $error("rise flag not set");
   property p_bit_clr;
      bit_acc && !scl_rise && !(start_pend_r && scl_fall) |=> !clock_rise_flag_r && !start_int_r;
   endproperty
   a_bit_clr: assert property (p_bit_clr) else $error("flags not cleared");
   property p_ctl_clr;
      ctl_wr && !sfr_wdata[B_RISE] && !scl_rise |=> !read_bit_done && !write_bit_done;
   endproperty
   a_ctl_clr: assert property (p_ctl_clr) else $error("done flags survive clear");
   property p_busy;
      start_ev |=> bus_busy_flag_r ##0 stretch_hold_flag_r;
   endproperty
   a_busy: assert property (p_busy) else $error("start not recorded");
   property p_stop;
      stop_ev |=> !bus_busy_flag_r;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not recorded");
   property p_hold;
      stretch_hold_flag_r && serial_io_enable_r |=> !scl_oe_n_r;
   endproperty
   a_hold: assert property (p_hold) else $error("clock not held low");
   property p_auto;
      $rose(auto_high) |-> $past(auto_launch, AUTO_DELAY_CYC);
   endproperty
   a_auto: assert property (p_auto) else $error("auto-clock late or early");
   property p_ctl_noauto;
      ctl_wr && auto_st_r == AC_IDLE && !bit_acc |=> auto_st_r == AC_IDLE;
   endproperty
   a_ctl_noauto: assert property (p_ctl_noauto) else $error("control write started clock");
   property p_rd_done;
      sfr_rd && sfr_addr == ADDR_CTL && !clock_rise_flag_r |=> !sfr_rdata_r[B_RDONE];
   endproperty
   a_rd_done: assert property (p_rd_done) else $error("read done without rise");
   property p_mask;
      clock_out_bit_r && serial_io_enable_r && !stretch_hold_flag_r |=> scl_oe_n_r;
   endproperty
   a_mask: assert property (p_mask) else $error("clock pulled with bit high");
   c_start: cover property (start_ev ##[1:1000] start_int_r);
   c_auto: cover property (auto_launch ##[1:300] $fell(auto_high));
   c_stretch: cover property (scl_fall && stretch_control_r ##1 stretch_hold_flag_r);
   c_wdone: cover property (write_bit_done);
endmodule // bic_ctl

// ### rtl/bic_filter.sv
// Two-stage synchroniser and glitch filter for one bus line
`timescale 1ns/1ps
module bic_filter
   import bic_pkg::*;
#(
   parameter int FILT_LEN = FILT_LEN_DEF
)(
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic line_in,
   output logic      filt_r
);
   logic             sync1_r;
   logic             sync2_r;
   logic [CNT_W-1:0] stab_cnt_r;

   // Synchroniser; only the second stage reads the first
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sync1_r <= LINE_IDLE;
         sync2_r <= LINE_IDLE;
      end
      else
      begin
         sync1_r <= line_in;
         sync2_r <= sync1_r;
      end
   end

   // New level is accepted only after it has stood FILT_LEN samples
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         stab_cnt_r <= CNT_ZERO;
         filt_r     <= LINE_IDLE;
      end
      else if (sync2_r == filt_r)
         stab_cnt_r <= CNT_ZERO;
      else if (stab_cnt_r == CNT_W'(FILT_LEN - 1))
      begin
         stab_cnt_r <= CNT_ZERO;
         filt_r     <= sync2_r;
      end
      else
         stab_cnt_r <= stab_cnt_r + CNT_ONE;
   end
endmodule // bic_filter

// ### sim/bic_bus_model.sv
// Behavioural far-side bus master: drives start, stop and single bits
`timescale 1ns/1ps
module bic_bus_model (
   input  wire logic ref_clk,
   input  wire logic scl_line,
   output logic      scl_oe_n,
   output logic      sda_oe_n
);
   // Both lines released at time zero; pull-ups hold them high
   initial
   begin
      scl_oe_n = 1'b1;
      sda_oe_n = 1'b1;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // Pull (0) or release (1) both lines just after an edge
   task automatic drv(input logic c, input logic d);
      @(posedge ref_clk);
      scl_oe_n <= c;
      sda_oe_n <= d;
   endtask

   // Data falls while the clock is high, then the clock falls
   task automatic start();
      drv(1'b1, 1'b0);
      wt(10);
      drv(1'b0, 1'b0);
      wt(10);
   endtask

   // Low halves of 11 cycles and high halves of at least 12 give a link clock period of 184 ns or more
   task automatic bit_pulse(input logic b);
      int k;
      drv(1'b0, b);
      wt(10);
      drv(1'b1, b);
      k = 0;
      // A stretched clock is waited for, with a bound
      while (scl_line !== 1'b1 && k < 400)
      begin
         @(posedge ref_clk);
         k++;
      end
      wt(10);
      drv(1'b0, b);
      wt(10);
   endtask

   // Clock low first so data moves only while the clock is low, except the final release that makes the stop
   task automatic stop();
      drv(1'b0, sda_oe_n);
      wt(10);
      drv(1'b0, 1'b0);
      wt(10);
      drv(1'b1, 1'b0);
      wt(10);
      drv(1'b1, 1'b1);
      wt(10);
   endtask
endmodule  // bic_bus_model

// ### sim/bic_ctl_test.sv
// Self-checking bench for the two-wire bus control and status block
`timescale 1ns/1ps
module bic_ctl_test;
   import bic_pkg::*;
   logic       ref_clk, rst, sfr_rd, sfr_rmw, sfr_wr;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_r, rv;
   logic       scl_out_r, scl_oe_n_r, sda_out_r, sda_oe_n_r, m_scl_oe_n, m_sda_oe_n;
   int         n_fail, checks, d, len, b;
   // Wired-AND lines with pull-ups
   wire logic  scl_line = (scl_oe_n_r | scl_out_r) & m_scl_oe_n;
   wire logic  sda_line = (sda_oe_n_r | sda_out_r) & m_sda_oe_n;

   bic_ctl u_bic_ctl (.ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
      .sfr_rmw(sfr_rmw), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r),
      .scl_in(scl_line), .scl_out_r(scl_out_r), .scl_oe_n_r(scl_oe_n_r),
      .sda_in(sda_line), .sda_out_r(sda_out_r), .sda_oe_n_r(sda_oe_n_r));
   bic_bus_model u_bic_bus_model (.ref_clk(ref_clk), .scl_line(scl_line),
      .scl_oe_n(m_scl_oe_n), .sda_oe_n(m_sda_oe_n));

   // 125 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic cmp(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      sfr_addr  <= a;
      sfr_wdata <= v;
      sfr_wr    <= 1'b1;
      @(posedge ref_clk);
      sfr_wr    <= 1'b0;
   endtask

   // Read data is registered, so it is taken one edge after the strobe drops
   task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] v);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_rd   <= 1'b1;
      sfr_rmw  <= m;
      @(posedge ref_clk);
      sfr_rd   <= 1'b0;
      sfr_rmw  <= 1'b0;
      @(posedge ref_clk);
      #1 v = sfr_rdata_r;
   endtask

   // Cycles until the clock line is released, then how long it stays released
   task automatic pulse_len(output int dly, output int hi);
      #1 dly = 1;
      hi = 0;
      while (scl_oe_n_r !== 1'b1 && dly < 300)
      begin
         @(posedge ref_clk);
         #1 dly++;
      end
      while (scl_oe_n_r === 1'b1 && hi < 400)
      begin
         @(posedge ref_clk);
         #1 hi++;
      end
   endtask

   // Status after a finished bit while the bus is busy and the clock is low
   function automatic logic [7:0] exp_bit(input logic data_in_filtered, input logic wdone);
      return {data_in_filtered, 1'b0, 1'b1, 1'b1, 1'b1, wdone, 1'b0, 1'b1};
   endfunction

   task automatic end_of_test();
      $display("Counts: %0d checks, %0d mismatches", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Watchdog well beyond the fourteen hundred or so cycles the tests need
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      n_fail++;
      end_of_test();
   end

   // Main sequence
   initial
   begin
      rst = 1'b1;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_rd = 1'b0;
      sfr_rmw = 1'b0;
      sfr_wr = 1'b0;
      n_fail = 0;
      checks = 0;
      b = $urandom(32'h6b3b);
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      rd(ADDR_CTL, 1'b0, rv);
      cmp("ctl reset", rv, RST_CTL);
      rd(ADDR_CTL, 1'b1, rv);
      cmp("ctl rmw", rv, RST_CTL);
      rd(8'h55, 1'b0, rv);
      cmp("unmapped", rv, RD_ZERO);
      $display("reset test done");
      // Output bits already high before enabling
      wr(ADDR_CTL, 8'hc1);
      u_bic_bus_model.start();
      #1 cmp("stretch on start", 8'(scl_oe_n_r), 8'h00);
      rd(ADDR_CTL, 1'b0, rv);
      cmp("busy", 8'(rv[B_BUSY]), 8'h01);
      rd(ADDR_START, 1'b0, rv);
      cmp("start flag", 8'(rv[B_START]), 8'h01);
      rd(ADDR_BIT, 1'b0, rv);
      repeat (3) @(posedge ref_clk);
      #1 cmp("stretch end", 8'(scl_oe_n_r), 8'h01);
      rd(ADDR_START, 1'b0, rv);
      cmp("start cleared", 8'(rv[B_START]), 8'h00);
      $display("start test done");
      // Random bits from the far master; a 0 over a 1 loses arbitration
      for (int i = 0; i < 8; i++)
      begin
         b = $urandom_range(1, 0);
         u_bic_bus_model.bit_pulse(b[0]);
         rd(ADDR_CTL, 1'b0, rv);
         cmp("bit status", rv, exp_bit(b[0], b[0]));
         wr(ADDR_CTL, 8'hc1);
         rd(ADDR_CTL, 1'b0, rv);
         cmp("rise cleared", rv & 8'h2c, 8'h00);
      end
      $display("bit test done");
      wr(ADDR_CTL, 8'hc3);
      u_bic_bus_model.bit_pulse(1'b1);
      repeat (4) @(posedge ref_clk);
      #1 cmp("stretch hold", 8'(scl_oe_n_r), 8'h00);
      u_bic_bus_model.drv(1'b1, 1'b1);
      repeat (20) @(posedge ref_clk);
      #1 cmp("line held", 8'(scl_line), 8'h00);
      // Clock line is low here, so bit 6 can read back as one only from the output bit
      rd(ADDR_CTL, 1'b1, rv);
      cmp("rmw out bits", 8'(rv[7:6]), 8'h03);
      rd(ADDR_BIT, 1'b0, rv);
      cmp("bit reg", rv, 8'h80);
      repeat (3) @(posedge ref_clk);
      #1 cmp("stretch released", 8'(scl_oe_n_r), 8'h01);
      wr(ADDR_CTL, 8'hc1);
      u_bic_bus_model.bit_pulse(1'b1);
      #1 cmp("no stretch", 8'(scl_oe_n_r), 8'h01);
      $display("stretch test done");
      u_bic_bus_model.drv(1'b1, 1'b1);
      wr(ADDR_CTL, 8'h81);
      // The pull shows one cycle after the write
      @(posedge ref_clk);
      pulse_len(d, len);
      cmp("no auto from ctl", 8'(len), 8'h00);
      for (int i = 0; i < 2; i++)
      begin
         wr(ADDR_BIT, {i[0], 7'h00});
         pulse_len(d, len);
         cmp("data pin", 8'(sda_oe_n_r), 8'(i[0]));
         cmp("auto delay", 8'(d), 8'(AUTO_DELAY_CYC + 1));
         cmp("auto high", 8'(len), 8'(AUTO_HIGH_CYC));
         // Finished flags need the filtered clock low first
         repeat (10) @(posedge ref_clk);
         rd(ADDR_CTL, 1'b0, rv);
         cmp("auto status", rv, exp_bit(i[0], 1'b1));
      end
      // Far side holds the clock low across the auto pulse start
      b = $urandom_range(90, 60);
      wr(ADDR_BIT, 8'h80);
      fork
         begin
            u_bic_bus_model.drv(1'b0, 1'b1);
            u_bic_bus_model.wt(b);
            u_bic_bus_model.drv(1'b1, 1'b1);
         end
         pulse_len(d, len);
      join
      cmp("held pulse longer", 8'(len > AUTO_HIGH_CYC), 8'h01);
      $display("auto clock test done");
      // Software clocking: raise the clock bit, wait for the rise flag, lower it
      repeat (20) @(posedge ref_clk);
      wr(ADDR_CTL, 8'hc1);
      rd(ADDR_CTL, 1'b0, rv);
      rd(ADDR_CTL, 1'b0, rv);
      cmp("rise not early", 8'(rv[B_RISE]), 8'h00);
      for (int k = 0; k < 8 && !rv[B_RISE]; k++)
         rd(ADDR_CTL, 1'b0, rv);
      cmp("manual rise", 8'(rv[B_RISE]), 8'h01);
      wr(ADDR_CTL, 8'h81);
      repeat (2) @(posedge ref_clk);
      #1 cmp("manual low", 8'(scl_oe_n_r), 8'h00);
      cmp("line drive", {6'h00, scl_out_r, sda_out_r}, 8'h00);
      $display("manual clock test done");
      wr(ADDR_CTL, 8'hc1);
      u_bic_bus_model.stop();
      rd(ADDR_CTL, 1'b0, rv);
      cmp("busy after stop", 8'(rv[B_BUSY]), 8'h00);
      wr(ADDR_CTL, 8'hc0);
      u_bic_bus_model.start();
      #1 cmp("off no stretch", 8'(scl_oe_n_r), 8'h01);
      rd(ADDR_CTL, 1'b0, rv);
      cmp("off no busy", 8'(rv[B_BUSY]), 8'h00);
      u_bic_bus_model.stop();
      $display("disable test done");
      end_of_test();
   end
endmodule  // bic_ctl_test
